// [bzm_buzzer_model.sv]
/*
  buzzer element behind its power switch: counts pin edges while powered.
  assumes pin and power come from bzm_top registers on clk_sys.
*/
`timescale 1ns/1ps
`default_nettype none
module bzm_buzzer_model (
  input wire logic clk_sys,
  input wire logic pin,
  input wire logic power_en,
  output var int tone_edges
);
  logic last_r = 1'b0;
  int edges_r = 0;
  assign tone_edges = edges_r;
  // an unpowered element stays silent whatever the pin does
  always @(posedge clk_sys) begin
    last_r <= pin;
    if (power_en && pin !== last_r) edges_r <= edges_r + 1;
  end
endmodule
`default_nettype wire

// [bzm_checker.sv]
/*
  port checker for bzm_top, bound to every instance.
  assumes one clock domain clk_sys with active low reset rst_b.
*/
`timescale 1ns/1ps
`default_nettype none
module bzm_checker (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic note_a_start_cmd,
  input wire logic note_b_start_cmd,
  input wire logic power_window_flag_clr,
  input wire logic buzzer_enable,
  input wire logic buzzer_invert,
  input wire logic buzzer_out_r,
  input wire logic buzzer_power_on_r,
  input wire logic note_a_pending_r,
  input wire logic note_b_pending_r,
  input wire logic note_a_busy,
  input wire logic note_b_busy,
  input wire logic power_window_expired_flag_r
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  chk_pend_start: assert property (note_a_start_cmd |=> note_a_pending_r)
    else $error("start not held pending");
  chk_pwr_start: assert property ((note_a_start_cmd || note_b_start_cmd) |=> buzzer_power_on_r)
    else $error("power window not started");
  chk_busy_pend: assert property (!((note_a_busy && !note_a_pending_r) || (note_b_busy && !note_b_pending_r)))
    else $error("busy without pending");
  chk_one_note: assert property (!(note_a_busy && note_b_busy))
    else $error("both notes busy");
  chk_both_order: assert property (note_a_start_cmd && note_b_start_cmd && !note_a_pending_r && !note_b_pending_r
    |-> ##2 note_a_busy && !note_b_busy)
    else $error("note a not first");
  chk_pw_sticky: assert property (power_window_expired_flag_r && !power_window_flag_clr
    |=> power_window_expired_flag_r)
    else $error("expiry flag lost");
  chk_pw_set: assert property ($fell(buzzer_power_on_r) |-> power_window_expired_flag_r)
    else $error("expiry flag not set");
  chk_pw_clear: assert property (power_window_flag_clr && !buzzer_power_on_r |=> !power_window_expired_flag_r)
    else $error("expiry flag not cleared");
  // pin may leave its idle level only after an enabled busy cycle
  chk_pin_idle: assert property (buzzer_out_r != $past(buzzer_invert)
    |-> $past(buzzer_enable && (note_a_busy || note_b_busy)))
    else $error("pin active while idle");
  cover property (note_a_start_cmd && note_b_start_cmd);
  cover property ($rose(power_window_expired_flag_r));
  cover property ($rose(note_b_busy) && note_a_pending_r);
endmodule
bind bzm_top bzm_checker chk_u (.*);
`default_nettype wire

// [bzm_pkg.sv]
/*
  constants shared by the buzzer and melody tone generator.
  assumes a single system clock of 50 mhz and an active low asynchronous reset.
*/
`default_nettype none
package bzm_pkg;
  localparam int CLK_PERIOD_NS = 20;
  // one millisecond expressed in ns, the smallest time unit step
  localparam int TIME_STEP_NS = 1000000;
  localparam int MS_CYCLES = (TIME_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // tone base divides; the tone counter runs at half the base period for a 50 percent duty square
  localparam int BASE_DIV_LO = 32;
  localparam int BASE_DIV_HI = 64;
  localparam int HALF_DIV_LO = BASE_DIV_LO / 2;
  localparam int HALF_DIV_HI = BASE_DIV_HI / 2;
  localparam int PRE_W = 5;
  localparam int TONE_DIV_W = 12;
  localparam int TIME_W = 8;
  localparam int UNIT_SEL_W = 2;
  localparam int UNIT_W = 3;
  // time unit select encodings
  localparam logic [UNIT_SEL_W-1:0] UNIT_1MS = 2'h0;
  localparam logic [UNIT_SEL_W-1:0] UNIT_2MS = 2'h1;
  localparam logic [UNIT_SEL_W-1:0] UNIT_4MS = 2'h2;
  localparam logic [UNIT_SEL_W-1:0] UNIT_8MS = 2'h3;
  // reset values
  localparam logic [TIME_W-1:0] TIME_RST = 8'h00;
  localparam logic [TONE_DIV_W-1:0] DIV_RST = 12'h000;

  typedef enum logic [2:0] {
    BZM_IDLE,
    BZM_A_TONE,
    BZM_A_PAUSE,
    BZM_B_TONE,
    BZM_B_PAUSE
  } bzm_state_t;
endpackage
`default_nettype wire

// [bzm_tb.sv]
/*
  self-checking bench for bzm_top with buzzer model and bound checker.
  assumes bzm_pkg is compiled first; ms count shortened to 10 cycles.
*/
`timescale 1ns/1ps
`default_nettype none
module tb;
  import bzm_pkg::*;
  localparam int MS = 10;
  logic clk_sys = 0;
  logic rst_b = 0;
  logic [TONE_DIV_W-1:0] note_a_tone_divisor = 0, note_b_tone_divisor = 0;
  logic [TIME_W-1:0] note_a_duration = 0, note_a_pause = 0, note_b_duration = 0, note_b_pause = 0;
  logic [TIME_W-1:0] power_window_length = 0;
  logic [UNIT_SEL_W-1:0] time_unit_select = 0;
  logic tone_base_select = 0, buzzer_enable = 1, buzzer_invert = 0;
  logic note_a_end_flag_en = 1, note_b_end_flag_en = 1, note_a_start_cmd = 0, note_b_start_cmd = 0;
  logic note_a_end_flag_clr = 0, note_b_end_flag_clr = 0, power_window_flag_clr = 0;
  logic buzzer_out_r, buzzer_power_on_r, note_a_pending_r, note_b_pending_r, note_a_busy, note_b_busy;
  logic note_a_end_flag_r, note_b_end_flag_r, power_window_expired_flag_r;
  int mismatches = 0;
  int samples_checked = 0;
  int n, k, tone_edges;
  bzm_top #(.MS_COUNT(MS)) dut_u (.*);
  bzm_buzzer_model bz_u (.clk_sys(clk_sys), .pin(buzzer_out_r), .power_en(buzzer_power_on_r),
    .tone_edges(tone_edges));
  always #10 clk_sys = ~clk_sys;
  task tally_and_finish;
    $display("mismatches %0d samples_checked %0d", mismatches, samples_checked);
    if (mismatches == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task check(input logic [15:0] seen, input logic [15:0] want);
    samples_checked++;
    if (seen !== want) begin
      mismatches++;
      $display("wrong value at %0t: got %0h want %0h", $time, seen, want);
    end
  endtask
  task automatic pulse(ref logic s);
    s = 1;
    @(negedge clk_sys);
    s = 0;
  endtask
  // bounded wait; n ends as the number of falling edges waited
  task automatic await(ref logic s, input logic v);
    n = 0;
    while (s !== v && n < 20000) begin
      @(negedge clk_sys);
      n++;
    end
    if (n >= 20000) begin
      mismatches++;
      tally_and_finish();
    end
  endtask
  task t_tone(input logic [11:0] d, input logic b, input int hp);
    note_a_tone_divisor = d;
    tone_base_select = b;
    pulse(note_a_start_cmd);
    await(buzzer_out_r, 1);
    await(buzzer_out_r, 0);
    check(16'(n), 16'(hp));
    check(16'(tone_edges != 0), 16'h1);
    await(note_a_pending_r, 0);
  endtask
  task t_units;
    power_window_length = 8'h03;
    for (int sel = 0; sel < 4; sel++) begin
      // let the last clear pulse drop for a full cycle before raising it again
      @(negedge clk_sys);
      time_unit_select = 2'(sel);
      pulse(power_window_flag_clr);
      pulse(note_b_start_cmd);
      await(buzzer_power_on_r, 0);
      check(16'(n >= 2 * (MS << sel) && n <= 3 * (MS << sel) + 3), 16'h1);
      repeat (5) @(negedge clk_sys);
      check(16'(power_window_expired_flag_r), 16'h1);
      pulse(power_window_flag_clr);
      check(16'(power_window_expired_flag_r), 16'h0);
    end
  endtask
  task t_both;
    time_unit_select = UNIT_1MS;
    note_a_duration = 8'h03;
    note_b_duration = 8'h02;
    note_b_pause = 8'h02;
    pulse(note_a_end_flag_clr);
    pulse(note_b_end_flag_clr);
    note_a_start_cmd = 1;
    note_b_start_cmd = 1;
    @(negedge clk_sys);
    note_a_start_cmd = 0;
    note_b_start_cmd = 0;
    await(note_a_busy, 1);
    check(16'({note_b_busy, note_b_pending_r}), 16'h1);
    await(note_b_busy, 1);
    check(16'({note_a_pending_r, note_a_end_flag_r}), 16'h1);
    pulse(note_a_start_cmd);
    await(note_b_pending_r, 0);
    check(16'(note_b_end_flag_r), 16'h1);
    await(note_a_busy, 1);
    check(16'(n <= 2), 16'h1);
    await(note_a_pending_r, 0);
    pulse(note_a_end_flag_clr);
    pulse(note_b_end_flag_clr);
    check(16'({note_a_end_flag_r, note_b_end_flag_r}), 16'h0);
  endtask
  // gated pin must sit at the inverted idle level for the whole note
  task t_gate;
    buzzer_enable = 0;
    buzzer_invert = 1;
    note_a_end_flag_en = 0;
    k = 0;
    pulse(note_a_start_cmd);
    for (int i = 0; i < 200; i++) begin
      @(negedge clk_sys);
      k += int'(buzzer_out_r !== 1'b1);
    end
    check(16'(k), 16'h0);
    check(16'(note_a_pending_r), 16'h0);
    check(16'(note_a_end_flag_r), 16'h0);
    note_a_end_flag_en = 1;
    buzzer_enable = 1;
    buzzer_invert = 0;
  endtask
  initial begin
    repeat (8) @(negedge clk_sys);
    rst_b = 1;
    check(16'({note_a_pending_r, note_b_pending_r, note_a_busy, note_b_busy, buzzer_power_on_r,
      power_window_expired_flag_r}), 16'h0);
    time_unit_select = UNIT_8MS;
    note_a_duration = 8'h40;
    note_a_pause = 8'h01;
    power_window_length = 8'hff;
    t_tone(12'h002, 0, 48);
    t_tone(12'h002, 1, 96);
    t_tone(12'h040, 1, 2080);
    t_units;
    t_both;
    t_gate;
    tally_and_finish();
  end
  initial begin
    #1500000;
    mismatches++;
    tally_and_finish();
  end
endmodule
`default_nettype wire

// [bzm_tone_gen.sv]
/*
  tone square wave generator: prescale by half the base divide, then by divisor plus one.
  assumes run, base_sel and divisor come from logic on clk_sys.
*/
`timescale 1ns/1ps
`default_nettype none
module bzm_tone_gen
  import bzm_pkg::*;
#(
  parameter int DIV_W = TONE_DIV_W
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic run,
  input wire logic base_sel,
  input wire logic [DIV_W-1:0] divisor,
  output var logic tone_r
);
  logic [PRE_W-1:0] pre_r;
  logic [DIV_W-1:0] div_r;
  logic [PRE_W-1:0] pre_term;
  logic half_tick;

  // toggling every divisor+1 half base periods gives base/(divisor+1) with even duty
  assign pre_term = base_sel ? PRE_W'(HALF_DIV_HI - 1) : PRE_W'(HALF_DIV_LO - 1);
  assign half_tick = (pre_r == pre_term);

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      pre_r <= '0;
    end else if (!run || half_tick) begin
      pre_r <= '0;
    end else begin
      pre_r <= pre_r + PRE_W'(1);
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      div_r <= '0;
      tone_r <= 1'b0;
    end else if (!run) begin
      div_r <= '0;
      tone_r <= 1'b0;
    end else if (half_tick) begin
      if (div_r >= divisor) begin
        div_r <= '0;
        tone_r <= ~tone_r;
      end else begin
        div_r <= div_r + DIV_W'(1);
      end
    end
  end
endmodule
`default_nettype wire

// [bzm_top.sv]
/*
  buzzer and melody controller: two note buffers, sequencer, time unit base,
  power window timer and buzzer pin driver.
  assumes every control input is driven by logic on clk_sys; start, clear
  inputs are one-cycle pulses from a register write.
*/
`timescale 1ns/1ps
`default_nettype none
module bzm_top
  import bzm_pkg::*;
#(
  parameter int MS_COUNT = MS_CYCLES
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic [TONE_DIV_W-1:0] note_a_tone_divisor,
  input wire logic [TIME_W-1:0] note_a_duration,
  input wire logic [TIME_W-1:0] note_a_pause,
  input wire logic [TONE_DIV_W-1:0] note_b_tone_divisor,
  input wire logic [TIME_W-1:0] note_b_duration,
  input wire logic [TIME_W-1:0] note_b_pause,
  input wire logic [TIME_W-1:0] power_window_length,
  input wire logic [UNIT_SEL_W-1:0] time_unit_select,
  input wire logic tone_base_select,
  input wire logic buzzer_enable,
  input wire logic buzzer_invert,
  input wire logic note_a_end_flag_en,
  input wire logic note_b_end_flag_en,
  input wire logic note_a_start_cmd,
  input wire logic note_b_start_cmd,
  input wire logic note_a_end_flag_clr,
  input wire logic note_b_end_flag_clr,
  input wire logic power_window_flag_clr,
  output var logic buzzer_out_r,
  output var logic buzzer_power_on_r,
  output var logic note_a_pending_r,
  output var logic note_b_pending_r,
  output logic note_a_busy,
  output logic note_b_busy,
  output var logic note_a_end_flag_r,
  output var logic note_b_end_flag_r,
  output var logic power_window_expired_flag_r
);
  localparam int MS_W = $clog2(MS_COUNT + 1);

  bzm_state_t state_r;
  bzm_state_t state_nxt;
  logic [MS_W-1:0] ms_r;
  logic [UNIT_W-1:0] unit_r;
  logic ms_tick;
  logic unit_tick;
  logic [TIME_W-1:0] cnt_r;
  logic [TIME_W-1:0] cnt_nxt;
  logic cnt_load;
  logic [TIME_W-1:0] pw_cnt_r;
  logic a_done;
  logic b_done;
  logic tone_run;
  logic tone_level;
  logic [TONE_DIV_W-1:0] tone_div;

  // last ms count of one unit step for each time unit code
  function automatic logic [UNIT_W-1:0] unit_span(input logic [UNIT_SEL_W-1:0] code);
    case (code)
      UNIT_1MS: unit_span = 3'h0;
      UNIT_2MS: unit_span = 3'h1;
      UNIT_4MS: unit_span = 3'h3;
      UNIT_8MS: unit_span = 3'h7;
      default: unit_span = 3'h0;
    endcase
  endfunction

  // free running base: the first unit of a note may be short by up to one unit
  assign ms_tick = (ms_r == MS_W'(MS_COUNT - 1));
  assign unit_tick = ms_tick && (unit_r >= unit_span(time_unit_select));

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      ms_r <= '0;
    end else if (ms_tick) begin
      ms_r <= '0;
    end else begin
      ms_r <= ms_r + MS_W'(1);
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      unit_r <= '0;
    end else if (unit_tick) begin
      unit_r <= '0;
    end else if (ms_tick) begin
      unit_r <= unit_r + UNIT_W'(1);
    end
  end

  // a note finishes when its pause reaches zero
  assign a_done = (state_r == BZM_A_PAUSE) && (cnt_r == TIME_RST);
  assign b_done = (state_r == BZM_B_PAUSE) && (cnt_r == TIME_RST);

  // start wins over the self clear so a restart at completion is kept
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      note_a_pending_r <= 1'b0;
      note_b_pending_r <= 1'b0;
    end else begin
      note_a_pending_r <= note_a_start_cmd || (note_a_pending_r && !a_done);
      note_b_pending_r <= note_b_start_cmd || (note_b_pending_r && !b_done);
    end
  end

  always_comb begin
    state_nxt = state_r;
    cnt_load = 1'b0;
    cnt_nxt = cnt_r;
    case (state_r)
      BZM_IDLE: begin
        if (note_a_pending_r) begin
          state_nxt = BZM_A_TONE;
          cnt_load = 1'b1;
          cnt_nxt = note_a_duration;
        end else if (note_b_pending_r) begin
          state_nxt = BZM_B_TONE;
          cnt_load = 1'b1;
          cnt_nxt = note_b_duration;
        end
      end
      BZM_A_TONE: begin
        if (cnt_r == TIME_RST) begin
          state_nxt = BZM_A_PAUSE;
          cnt_load = 1'b1;
          cnt_nxt = note_a_pause;
        end
      end
      BZM_A_PAUSE: begin
        if (cnt_r == TIME_RST) begin
          if (note_b_pending_r) begin
            state_nxt = BZM_B_TONE;
            cnt_load = 1'b1;
            cnt_nxt = note_b_duration;
          end else if (note_a_start_cmd) begin
            state_nxt = BZM_A_TONE;
            cnt_load = 1'b1;
            cnt_nxt = note_a_duration;
          end else begin
            state_nxt = BZM_IDLE;
          end
        end
      end
      BZM_B_TONE: begin
        if (cnt_r == TIME_RST) begin
          state_nxt = BZM_B_PAUSE;
          cnt_load = 1'b1;
          cnt_nxt = note_b_pause;
        end
      end
      BZM_B_PAUSE: begin
        if (cnt_r == TIME_RST) begin
          if (note_a_pending_r) begin
            state_nxt = BZM_A_TONE;
            cnt_load = 1'b1;
            cnt_nxt = note_a_duration;
          end else if (note_b_start_cmd) begin
            state_nxt = BZM_B_TONE;
            cnt_load = 1'b1;
            cnt_nxt = note_b_duration;
          end else begin
            state_nxt = BZM_IDLE;
          end
        end
      end
      default: begin
        state_nxt = BZM_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= BZM_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      cnt_r <= TIME_RST;
    end else if (cnt_load) begin
      cnt_r <= cnt_nxt;
    end else if (unit_tick && (cnt_r != TIME_RST)) begin
      cnt_r <= cnt_r - TIME_W'(1);
    end
  end

  assign note_a_busy = (state_r == BZM_A_TONE) || (state_r == BZM_A_PAUSE);
  assign note_b_busy = (state_r == BZM_B_TONE) || (state_r == BZM_B_PAUSE);

  // one shared generator; the idle buffer's settings may change freely
  assign tone_run = (state_r == BZM_A_TONE) || (state_r == BZM_B_TONE);
  assign tone_div = (state_r == BZM_B_TONE) ? note_b_tone_divisor : note_a_tone_divisor;

  bzm_tone_gen #(
    .DIV_W(TONE_DIV_W)
  ) u_tone (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .run(tone_run),
    .base_sel(tone_base_select),
    .divisor(tone_div),
    .tone_r(tone_level)
  );

  // pin sits at its inactive level outside the tone phase
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      buzzer_out_r <= 1'b0;
    end else begin
      buzzer_out_r <= (buzzer_enable && tone_run && tone_level) ^ buzzer_invert;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      note_a_end_flag_r <= 1'b0;
      note_b_end_flag_r <= 1'b0;
    end else begin
      note_a_end_flag_r <= (a_done && note_a_end_flag_en) || (note_a_end_flag_r && !note_a_end_flag_clr);
      note_b_end_flag_r <= (b_done && note_b_end_flag_en) || (note_b_end_flag_r && !note_b_end_flag_clr);
    end
  end

  // power window restarts on every start command
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      pw_cnt_r <= TIME_RST;
      buzzer_power_on_r <= 1'b0;
    end else if (note_a_start_cmd || note_b_start_cmd) begin
      pw_cnt_r <= power_window_length;
      buzzer_power_on_r <= 1'b1;
    end else if (buzzer_power_on_r) begin
      if (pw_cnt_r == TIME_RST) begin
        buzzer_power_on_r <= 1'b0;
      end else if (unit_tick) begin
        pw_cnt_r <= pw_cnt_r - TIME_W'(1);
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      power_window_expired_flag_r <= 1'b0;
    end else begin
      power_window_expired_flag_r <= (buzzer_power_on_r && (pw_cnt_r == TIME_RST) && !note_a_start_cmd
        && !note_b_start_cmd) || (power_window_expired_flag_r && !power_window_flag_clr);
    end
  end
endmodule
`default_nettype wire
